/* jifa_dev.sv */
// Device end: test access port with indirect flash registers and flash array
`timescale 1ns/100ps
`default_nettype none
module jifa_dev #(
  parameter int          AW         = jifa_pkg::FLASH_AW,
  parameter int          OPS        = jifa_pkg::OP_CYCLES,
  parameter logic [3:0]  ID_VERSION = 4'h5,     // Arbitrary value
  parameter logic [15:0] ID_PART    = 16'h5a3c, // Arbitrary value
  parameter logic [10:0] ID_MFR     = 11'h2a5   // Arbitrary value
) (
  input  wire logic       CLOCK,       // System clock, 100 MHz
  input  wire logic       RST_N,       // Async reset, active low
  jifa_link_if.dev        LINK,        // Test access link
  output logic            FLASH_BUSY,  // Indirect operation in progress
  output logic      [7:0] FLASH_SCALE  // Timing prescale register
);

  // ==========================================================================
  // Parameter checks
  if (AW > 16 || AW <= jifa_pkg::PAGE_AW) begin : g_bad_aw
    $error("flash address width out of range");
  end
  if (OPS < 1 || OPS > 255) begin : g_bad_ops
    $error("operation cycle count out of range");
  end

  typedef struct packed {
    jifa_pkg::jifa_tap_t tap;
    logic [15:0]         ir;
    logic [15:0]         irs;
    logic [31:0]         sr;
    logic                tdo;
    logic                busy;
    logic                erasing;
    logic                wr;
    logic [15:0]         op_ir;
    logic [17:0]         pay;
    logic [7:0]          cnt;
    logic [AW-1:0]       ptr;
    logic [AW-1:0]       last;
    logic [17:0]         rdres;
    logic [7:0]          fcon;
    logic [7:0]          fdat;
    logic [7:0]          fscl;
    logic [15:0]         fadr;
  } jifa_dev_st_t;

  jifa_dev_st_t q;
  jifa_dev_st_t d;
  logic [7:0]   mem [0:(1<<AW)-1];
  logic         mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0]   mem_wd;
  logic [7:0]   mem_rd;
  logic [2:0]   pin_lvl;
  logic [2:0]   pin_rise;
  logic [2:0]   pin_fall;
  logic         tck_rise;
  logic         tck_fall;
  logic         tms;
  logic         tdi;
  logic [31:0]  id_word;

  // ==========================================================================
  // Decoding helpers
  // indirect register codes
  function automatic logic is_ind(input logic [15:0] ir);
    return ir == jifa_pkg::IR_FCON || ir == jifa_pkg::IR_FDAT ||
           ir == jifa_pkg::IR_FADR || ir == jifa_pkg::IR_FSCL;
  endfunction

  // Top bit of the selected data register
  function automatic logic [4:0] dr_msb(input logic [15:0] ir);
    if (ir == jifa_pkg::IR_IDENT) begin
      return 5'(jifa_pkg::ID_W - 1);
    end else if (is_ind(ir)) begin
      return 5'(jifa_pkg::IND_W - 1);
    end
    return 5'h00;
  endfunction

  function automatic jifa_pkg::jifa_tap_t tap_next(input jifa_pkg::jifa_tap_t s,
                                                   input logic m);
    unique case (s)
      jifa_pkg::T_TLR:   return m ? jifa_pkg::T_TLR   : jifa_pkg::T_RTI;
      jifa_pkg::T_RTI:   return m ? jifa_pkg::T_SELDR : jifa_pkg::T_RTI;
      jifa_pkg::T_SELDR: return m ? jifa_pkg::T_SELIR : jifa_pkg::T_CAPDR;
      jifa_pkg::T_CAPDR: return m ? jifa_pkg::T_EX1DR : jifa_pkg::T_SHDR;
      jifa_pkg::T_SHDR:  return m ? jifa_pkg::T_EX1DR : jifa_pkg::T_SHDR;
      jifa_pkg::T_EX1DR: return m ? jifa_pkg::T_UPDR  : jifa_pkg::T_PSDR;
      jifa_pkg::T_PSDR:  return m ? jifa_pkg::T_EX2DR : jifa_pkg::T_PSDR;
      jifa_pkg::T_EX2DR: return m ? jifa_pkg::T_UPDR  : jifa_pkg::T_SHDR;
      jifa_pkg::T_UPDR:  return m ? jifa_pkg::T_SELDR : jifa_pkg::T_RTI;
      jifa_pkg::T_SELIR: return m ? jifa_pkg::T_TLR   : jifa_pkg::T_CAPIR;
      jifa_pkg::T_CAPIR: return m ? jifa_pkg::T_EX1IR : jifa_pkg::T_SHIR;
      jifa_pkg::T_SHIR:  return m ? jifa_pkg::T_EX1IR : jifa_pkg::T_SHIR;
      jifa_pkg::T_EX1IR: return m ? jifa_pkg::T_UPIR  : jifa_pkg::T_PSIR;
      jifa_pkg::T_PSIR:  return m ? jifa_pkg::T_EX2IR : jifa_pkg::T_PSIR;
      jifa_pkg::T_EX2IR: return m ? jifa_pkg::T_UPIR  : jifa_pkg::T_SHIR;
      jifa_pkg::T_UPIR:  return m ? jifa_pkg::T_SELDR : jifa_pkg::T_RTI;
    endcase
  endfunction

  // ==========================================================================
  // Link pins cross into the system clock
  jifa_sync #(.W(3)) u_sync (
    .CLOCK (CLOCK),
    .RST_N (RST_N),
    .D     ({LINK.tdi, LINK.tms, LINK.tck}),
    .LVL   (pin_lvl),
    .RISE  (pin_rise),
    .FALL  (pin_fall)
  );

  assign tck_rise = pin_rise[0];
  assign tck_fall = pin_fall[0];
  assign tms      = pin_lvl[1];
  assign tdi      = pin_lvl[2];

  // identity layout, bit 0 fixed high as the scan standard asks
  assign id_word = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

  // Asynchronous read keeps the byte read to a single engine cycle
  assign mem_rd = mem[q.fadr[AW-1:0]];

  // ==========================================================================
  // Scan port and indirect operation engine
  always_comb begin
    d      = q;
    mem_we = 1'b0;
    mem_wa = q.fadr[AW-1:0];
    mem_wd = q.fdat;
    if (tck_rise) begin
      case (q.tap)
        jifa_pkg::T_TLR: d.ir = jifa_pkg::IR_IDENT;
        jifa_pkg::T_CAPDR: begin
          if (is_ind(q.ir)) begin
            d.sr = {12'h000, 1'b0, q.rdres, q.busy};
          end else if (q.ir == jifa_pkg::IR_IDENT) begin
            d.sr = id_word;
          end else begin
            d.sr = 32'h0000_0000;
          end
        end
        jifa_pkg::T_SHDR: begin
          d.sr                = q.sr >> 1;
          d.sr[dr_msb(q.ir)]  = tdi;
        end
        jifa_pkg::T_UPDR: begin
          if (is_ind(q.ir) && q.sr[jifa_pkg::OPC_MSB] && !q.busy) begin
            d.busy  = 1'b1;
            d.wr    = q.sr[jifa_pkg::OPC_LSB];
            d.op_ir = q.ir;
            d.pay   = q.sr[jifa_pkg::PAY_W-1:0];
            d.cnt   = 8'(OPS - 1);
          end
        end
        jifa_pkg::T_CAPIR: d.irs = jifa_pkg::IR_CAPT;
        jifa_pkg::T_SHIR:  d.irs = {tdi, q.irs[15:1]};
        jifa_pkg::T_UPIR:  d.ir  = q.irs;
        default: ;
      endcase
      d.tap = tap_next(q.tap, tms);
    end
    // Output changes on the falling edge so the host samples a settled bit
    if (tck_fall) begin
      if (q.tap == jifa_pkg::T_SHDR) begin
        d.tdo = q.sr[0];
      end else if (q.tap == jifa_pkg::T_SHIR) begin
        d.tdo = q.irs[0];
      end
    end
    if (q.erasing) begin
      // Erase walks one byte per cycle
      mem_we = 1'b1;
      mem_wa = q.ptr;
      mem_wd = 8'hff;
      if (q.ptr == q.last) begin
        d.erasing = 1'b0;
        d.busy    = 1'b0;
      end else begin
        d.ptr = q.ptr + AW'(1);
      end
    end else if (q.busy) begin
      if (q.cnt != 8'h00) begin
        d.cnt = q.cnt - 8'h01;
      end else begin
        d.busy = 1'b0;
        if (!q.wr) begin
          case (q.op_ir)
            jifa_pkg::IR_FCON: d.rdres = {10'h000, q.fcon};
            jifa_pkg::IR_FADR: d.rdres = {2'h0, q.fadr};
            jifa_pkg::IR_FSCL: d.rdres = {10'h000, q.fscl};
            default: begin
              if (q.fcon[jifa_pkg::RDMD_LSB+:4] == jifa_pkg::RD_BYTE) begin
                d.fdat  = mem_rd;
                d.rdres = {10'h000, mem_rd};
              end else begin
                d.rdres = {10'h000, q.fdat};
              end
            end
          endcase
        end else begin
          case (q.op_ir)
            jifa_pkg::IR_FCON: d.fcon = q.pay[17:10];
            jifa_pkg::IR_FADR: d.fadr = q.pay[17:2];
            jifa_pkg::IR_FSCL: d.fscl = q.pay[17:10];
            default: begin
              d.fdat = q.pay[17:10];
              if (q.fcon[jifa_pkg::WRMD_LSB+:4] == jifa_pkg::WR_PROG) begin
                mem_we = 1'b1;
                mem_wd = q.pay[17:10];
                d.fadr = q.fadr + 16'h0001;
              end else if (q.fcon[jifa_pkg::WRMD_LSB+:4] == jifa_pkg::WR_ERASE) begin
                d.busy    = 1'b1;
                d.erasing = 1'b1;
                if (q.fadr == jifa_pkg::ERASE_ALL_ADDR) begin
                  d.ptr  = '0;
                  d.last = AW'(jifa_pkg::RESV_BASE - 16'h0001);
                end else begin
                  d.ptr  = {q.fadr[AW-1:jifa_pkg::PAGE_AW], {jifa_pkg::PAGE_AW{1'b0}}};
                  d.last = {q.fadr[AW-1:jifa_pkg::PAGE_AW], {jifa_pkg::PAGE_AW{1'b1}}};
                end
              end
            end
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      q       <= '0;
      q.tap   <= jifa_pkg::T_TLR;
      q.ir    <= jifa_pkg::IR_IDENT;
      q.fcon  <= jifa_pkg::FCON_RST;
      q.fdat  <= jifa_pkg::FDAT_RST;
      q.fscl  <= jifa_pkg::FSCL_RST;
      q.fadr  <= jifa_pkg::FADR_RST;
    end else begin
      q <= d;
    end
  end

  // Flash array has no reset; its content is undefined until erased
  always_ff @(posedge CLOCK) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign LINK.tdo    = q.tdo;
  assign FLASH_BUSY  = q.busy;
  assign FLASH_SCALE = q.fscl;

endmodule // jifa_dev
`default_nettype wire

/* jifa_pkg.sv */
// Shared constants and types for the indirect flash access link and its two ends
package jifa_pkg;

  // ==========================================================================
  // Instruction codes and scan layout
  localparam int          IR_W        = 16;
  localparam logic [15:0] IR_IDENT    = 16'h0004;
  localparam logic [15:0] IR_FCON     = 16'h0082;
  localparam logic [15:0] IR_FDAT     = 16'h0083;
  localparam logic [15:0] IR_FADR     = 16'h0084;
  localparam logic [15:0] IR_FSCL     = 16'h0085;
  localparam logic [15:0] IR_CAPT     = 16'h0001;
  localparam int          IND_W       = 20;
  localparam int          PAY_W       = 18;
  localparam int          OPC_MSB     = 19;
  localparam int          OPC_LSB     = 18;
  localparam int          ID_W        = 32;
  localparam int          ID_VER_LSB  = 28;
  localparam int          ID_PART_LSB = 12;
  localparam int          ID_MFR_LSB  = 1;

  // ==========================================================================
  // Flash access mode control fields and reset values
  localparam int         WRMD_LSB = 4;
  localparam int         RDMD_LSB = 0;
  localparam logic [3:0] WR_STORE = 4'h0;
  localparam logic [3:0] WR_PROG  = 4'h1;
  localparam logic [3:0] WR_ERASE = 4'h2;
  localparam logic [3:0] RD_STORE = 4'h0;
  localparam logic [3:0] RD_BYTE  = 4'h1;
  localparam logic [7:0] FCON_RST = 8'h00;
  localparam logic [7:0] FDAT_RST = 8'h00;
  localparam logic [7:0] FSCL_RST = 8'h00;
  localparam logic [15:0] FADR_RST = 16'h0000;

  // ==========================================================================
  // Flash geometry and timing
  localparam int          FLASH_AW       = 15;
  localparam int          PAGE_AW        = 9;
  localparam logic [15:0] RESV_BASE      = 16'h7e00;
  localparam logic [15:0] ERASE_ALL_ADDR = 16'hffff;
  localparam int          OP_CYCLES      = 4;
  localparam int          CLK_NS         = 10;
  localparam int          TCK_PERIOD_NS  = 160;
  localparam int          TCK_HALF       = TCK_PERIOD_NS / (2 * CLK_NS);
  localparam int          TAP_RST_BITS   = 5;

  // ==========================================================================
  // Host register map
  localparam int          APB_AW       = 12;
  localparam logic [11:0] A_CTRL       = 12'h000;
  localparam logic [11:0] A_TX         = 12'h004;
  localparam logic [11:0] A_RX         = 12'h008;
  localparam logic [11:0] A_STAT       = 12'h00c;
  localparam int          CTRL_GO      = 0;
  localparam int          CTRL_IR      = 1;
  localparam int          CTRL_TRST    = 2;
  localparam int          CTRL_LEN_LSB = 8;
  localparam int          LEN_W        = 6;
  localparam int          SCAN_MAX     = 32;

  // ==========================================================================
  // State enumerations
  typedef enum logic [3:0] {
    T_TLR, T_RTI, T_SELDR, T_CAPDR, T_SHDR, T_EX1DR, T_PSDR, T_EX2DR, T_UPDR,
    T_SELIR, T_CAPIR, T_SHIR, T_EX1IR, T_PSIR, T_EX2IR, T_UPIR
  } jifa_tap_t;

  typedef enum logic [2:0] {
    P_NONE, P_RST, P_RTI, P_SELDR, P_SELIR, P_CAP, P_SHIFT, P_UPD
  } jifa_phase_t;

endpackage

/* jifa_link_if.sv */
// Four-wire test access link between the host end and the device end
`timescale 1ns/100ps
`default_nettype none
interface jifa_link_if;
  logic tck;   // Test clock, made by the host
  logic tms;   // Mode select
  logic tdi;   // Data toward device
  logic tdo;   // Data toward host

  modport dev  (input tck, input tms, input tdi, output tdo);
  modport host (output tck, output tms, output tdi, input tdo);
endinterface
`default_nettype wire

/* jifa_sync.sv */
// Two-flop synchroniser with edge detection for pins from another domain
`timescale 1ns/100ps
`default_nettype none
module jifa_sync #(
  parameter int W = 1
) (
  input  wire logic         CLOCK,  // System clock
  input  wire logic         RST_N,  // Async reset, active low
  input  wire logic [W-1:0] D,      // Asynchronous inputs
  output logic      [W-1:0] LVL,    // Synchronised level
  output logic      [W-1:0] RISE,   // One-cycle rising pulse
  output logic      [W-1:0] FALL    // One-cycle falling pulse
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } jifa_sync_st_t;

  jifa_sync_st_t q;
  jifa_sync_st_t d;

  // ==========================================================================
  // Chain; only the second stage reads the first
  always_comb begin
    d    = q;
    d.s1 = D;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Edges compare the stable stages only
  assign LVL  = q.s2;
  assign RISE = q.s2 & ~q.s3;
  assign FALL = ~q.s2 & q.s3;

endmodule // jifa_sync
`default_nettype wire

/* jifa_host.sv */
// Host end: APB-programmed scan engine that drives the test access link
`timescale 1ns/100ps
`default_nettype none
module jifa_host #(
  parameter int HALF = jifa_pkg::TCK_HALF
) (
  input  wire logic        CLOCK,    // System clock, 100 MHz
  input  wire logic        RST_N,    // Async reset, active low
  input  wire logic        PSEL,     // APB select
  input  wire logic        PENABLE,  // APB access phase
  input  wire logic        PWRITE,   // APB direction
  input  wire logic [11:0] PADDR,    // APB byte address
  input  wire logic [31:0] PWDATA,   // APB write data
  output logic      [31:0] PRDATA,   // APB read data
  output logic             PREADY,   // APB ready
  output logic             PSLVERR,  // APB error, unmapped address
  jifa_link_if.host        LINK      // Test access link
);

  // Device sees edges late through its synchroniser; shorter halves race it
  if (HALF < 8 || HALF > 255) begin : g_bad_half
    $error("test clock half period out of range");
  end

  typedef struct packed {
    jifa_pkg::jifa_phase_t ph;
    logic        bit_on;
    logic [7:0]  div;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic [5:0]  cnt;
    logic [5:0]  len;
    logic        irscan;
    logic [31:0] tx;
    logic [31:0] rx;
    logic        first;
    logic        pend;
    logic        busy;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } jifa_host_st_t;

  jifa_host_st_t q;
  jifa_host_st_t d;
  logic          tdo;
  logic          last_bit;
  logic          new_req;
  logic [5:0]    wlen;

  // Returning data crosses from the device side
  jifa_sync #(.W(1)) u_sync (
    .CLOCK (CLOCK),
    .RST_N (RST_N),
    .D     (LINK.tdo),
    .LVL   (tdo),
    .RISE  (),
    .FALL  ()
  );

  assign last_bit = (q.cnt == q.len - 6'd1);
  assign wlen     = PWDATA[jifa_pkg::CTRL_LEN_LSB+:jifa_pkg::LEN_W];
  // last two bits shifted form the opcode
  assign new_req  = !q.irscan && q.len >= 6'd2 && q.tx[5'(q.len - 6'd1)];

  // ==========================================================================
  // APB slave and scan sequencer
  always_comb begin
    d        = q;
    d.pready = PSEL & ~PENABLE;
    if (PSEL && !PENABLE) begin
      d.pslverr = 1'b0;
      case (PADDR)
        jifa_pkg::A_CTRL: d.prdata = {18'h00000, q.len, 6'h00, q.irscan, 1'b0};
        jifa_pkg::A_TX:   d.prdata = q.tx;
        jifa_pkg::A_RX:   d.prdata = q.rx;
        jifa_pkg::A_STAT: d.prdata = {30'h0000_0000, q.pend, q.busy};
        default: begin
          d.prdata  = 32'h0000_0000;
          d.pslverr = 1'b1;
        end
      endcase
    end
    // Writes land only at the sampled access edge; busy locks the engine
    if (PSEL && PENABLE && q.pready && PWRITE && !q.busy) begin
      if (PADDR == jifa_pkg::A_TX) begin
        d.tx = PWDATA;
      end else if (PADDR == jifa_pkg::A_CTRL) begin
        d.len    = wlen;
        d.irscan = PWDATA[jifa_pkg::CTRL_IR];
        if (PWDATA[jifa_pkg::CTRL_TRST]) begin
          d.ph   = jifa_pkg::P_RST;
          d.cnt  = 6'd0;
          d.busy = 1'b1;
        // instruction scans refused while an operation is pending
        end else if (PWDATA[jifa_pkg::CTRL_GO] && wlen != 6'd0 &&
                     wlen <= 6'(jifa_pkg::SCAN_MAX) &&
                     !(PWDATA[jifa_pkg::CTRL_IR] && q.pend)) begin
          d.ph   = jifa_pkg::P_SELDR;
          d.rx   = 32'h0000_0000;
          d.busy = 1'b1;
        end
      end
    end
    // One test clock bit: low half with pins set, then high half
    if (q.ph != jifa_pkg::P_NONE) begin
      if (!q.bit_on) begin
        d.bit_on = 1'b1;
        d.div    = 8'h00;
        d.tck    = 1'b0;
        d.tdi    = (q.ph == jifa_pkg::P_SHIFT) ? q.tx[q.cnt[4:0]] : 1'b0;
        unique case (q.ph)
          jifa_pkg::P_RST, jifa_pkg::P_SELDR,
          jifa_pkg::P_SELIR, jifa_pkg::P_UPD: d.tms = 1'b1;
          jifa_pkg::P_SHIFT:                  d.tms = last_bit;
          default:                            d.tms = 1'b0;
        endcase
      end else if (q.div != 8'(HALF - 1)) begin
        d.div = q.div + 8'h01;
      end else if (!q.tck) begin
        d.div = 8'h00;
        d.tck = 1'b1;
        if (q.ph == jifa_pkg::P_SHIFT) begin
          d.rx = {tdo, q.rx[31:1]};
          if (q.cnt == 6'd0) begin
            d.first = tdo;
          end
        end
      end else begin
        d.div    = 8'h00;
        d.tck    = 1'b0;
        d.bit_on = 1'b0;
        unique case (q.ph)
          jifa_pkg::P_RST: begin
            if (q.cnt == 6'(jifa_pkg::TAP_RST_BITS - 1)) begin
              d.ph = jifa_pkg::P_RTI;
            end else begin
              d.cnt = q.cnt + 6'd1;
            end
          end
          jifa_pkg::P_RTI: begin
            d.ph   = jifa_pkg::P_NONE;
            d.busy = 1'b0;
          end
          jifa_pkg::P_SELDR: begin
            d.ph  = q.irscan ? jifa_pkg::P_SELIR : jifa_pkg::P_CAP;
            d.cnt = 6'd0;
          end
          jifa_pkg::P_SELIR: d.ph = jifa_pkg::P_CAP;
          // Second low bit is the capturing edge into shift
          jifa_pkg::P_CAP: begin
            d.ph  = (q.cnt == 6'd0) ? jifa_pkg::P_CAP : jifa_pkg::P_SHIFT;
            d.cnt = (q.cnt == 6'd0) ? 6'd1 : 6'd0;
          end
          jifa_pkg::P_SHIFT: begin
            if (last_bit) begin
              d.ph = jifa_pkg::P_UPD;
              d.rx = q.rx >> (6'd32 - q.len);
              // pending until busy seen low; a new request wins
              if (!q.irscan) begin
                d.pend = (q.pend & q.first) | new_req;
              end
            end else begin
              d.cnt = q.cnt + 6'd1;
            end
          end
          jifa_pkg::P_UPD: d.ph = jifa_pkg::P_RTI;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // State register; reset walks the device port to idle
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      q      <= '0;
      q.ph   <= jifa_pkg::P_RST;
      q.busy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign PRDATA   = q.prdata;
  assign PREADY   = q.pready;
  assign PSLVERR  = q.pslverr;
  assign LINK.tck = q.tck;
  assign LINK.tms = q.tms;
  assign LINK.tdi = q.tdi;

endmodule // jifa_host
`default_nettype wire

/* jifa_asserts.sv */
// Checker for link framing and device busy timing
`timescale 1ns/100ps
`default_nettype none
module jifa_asserts (
  input wire logic CLOCK,      // System clock
  input wire logic RST_N,      // Async reset, active low
  input wire logic tck,        // Test clock
  input wire logic tms,        // Mode select
  input wire logic tdi,        // Data toward device
  input wire logic tdo,        // Data toward host
  input wire logic FLASH_BUSY  // Device operation running
);
  // ==========================================================================
  // Link framing and busy timing
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Each clock phase lasts at least eight system cycles
  property p_tck_hi; $rose(tck) |-> tck [*8]; endproperty
  a_tck_hi: assert property (p_tck_hi) else $error("Test clock high phase short");
  property p_tck_lo; $fell(tck) |-> !tck [*8]; endproperty
  a_tck_lo: assert property (p_tck_lo) else $error("Test clock low phase short");
  // Host changes its lines only while the clock is low
  property p_tms_hold; tck && $past(tck) |-> $stable(tms); endproperty
  a_tms_hold: assert property (p_tms_hold) else $error("Mode line moved in high phase");
  property p_tdi_hold; tck && $past(tck) |-> $stable(tdi); endproperty
  a_tdi_hold: assert property (p_tdi_hold) else $error("Data in moved in high phase");
  // Device output settles in the low phase, never while sampled
  property p_tdo_hold; tck && $past(tck) |-> $stable(tdo); endproperty
  a_tdo_hold: assert property (p_tdo_hold) else $error("Data out moved in high phase");
  // An operation starts only from an update, inside a high phase
  property p_busy_in_hi; $rose(FLASH_BUSY) |-> tck; endproperty
  a_busy_in_hi: assert property (p_busy_in_hi) else $error("Busy rose off an update");
  property p_busy_min; $rose(FLASH_BUSY) |-> FLASH_BUSY [*4]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("Busy dropped too soon");
  // Erase-all below the reserved top outlasts any delay range, so count the run
  logic [15:0] busy_run;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      busy_run <= 16'h0000;
    end else begin
      busy_run <= FLASH_BUSY ? busy_run + 16'h0001 : 16'h0000;
    end
  end
  property p_busy_end; busy_run < 16'h80e8; endproperty
  a_busy_end: assert property (p_busy_end) else $error("Busy never cleared");
endmodule // jifa_asserts
`default_nettype wire

/* jifa_bench.sv */
// Bench: APB-driven host end against the device end over the link
`timescale 1ns/100ps
`default_nettype none
module jifa_bench;
  // ==========================================================================
  // Signals and instances
  localparam logic [31:0] IDW = {4'h9, 16'h1234, 11'h155, 1'b1}; // Fields arbitrary
  logic        clock = 1'b0, rst_n, psel, penable, pwrite, pslverr, pready, busy, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  scale;
  int          err_total = 0, num_checks = 0, cycles = 0;
  jifa_link_if link ();
  jifa_dev #(.ID_VERSION(IDW[31:28]), .ID_PART(IDW[27:12]), .ID_MFR(IDW[11:1])) jifa_dev_inst (
    .CLOCK(clock), .RST_N(rst_n), .LINK(link), .FLASH_BUSY(busy), .FLASH_SCALE(scale));
  jifa_host jifa_host_inst (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LINK(link));
  jifa_asserts jifa_asserts_inst (.CLOCK(clock), .RST_N(rst_n), .tck(link.tck),
    .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .FLASH_BUSY(busy));
  // Clock and hang guard
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_total++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Shared tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One edge gap first, so a release and a new setup never share a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] tx,
                      output logic [31:0] rx);
    apb(1'b1, jifa_pkg::A_TX, tx, rx);
    apb(1'b1, jifa_pkg::A_CTRL, (32'(n) << 8) | (32'(ir) << 1) | 32'h1, rx);
    do apb(1'b0, jifa_pkg::A_STAT, 32'h0, rx); while (rx[0] !== 1'b0);
    apb(1'b0, jifa_pkg::A_RX, 32'h0, rx);
  endtask
  // Single-bit polls until the device reports idle
  task automatic idle();
    logic [31:0] q;
    do scan(1'b0, 1, 32'h0, q); while (q[0] !== 1'b0);
  endtask
  task automatic wr(input logic [15:0] ir, input int w, input logic [31:0] v);
    logic [31:0] q;
    scan(1'b1, 16, 32'(ir), q);
    scan(1'b0, w + 2, (32'h3 << w) | v, q);
    idle();
  endtask
  // Two-bit read command, poll, then busy plus w result bits
  task automatic rdx(input int w, input logic [31:0] exp);
    logic [31:0] q;
    scan(1'b0, 2, 32'h2, q);
    idle();
    scan(1'b0, w + 1, 32'h0, q);
    chk((q >> 1) & ((32'h1 << w) - 1), exp);
  endtask
  task automatic rd(input logic [15:0] ir, input int w, input logic [31:0] exp);
    scan(1'b1, 16, 32'(ir), r);
    rdx(w, exp);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_ident();
    scan(1'b1, 16, 32'(jifa_pkg::IR_IDENT), r);
    scan(1'b0, 32, 32'h0, r);
    chk(r, IDW);
    apb(1'b0, 12'h010, 32'h0, r);
    chk({r[30:0], perr}, 32'h1);
    $display("identity test done");
  endtask
  task automatic t_regs();
    wr(jifa_pkg::IR_FSCL, 8, 32'h5a);
    chk(32'(scale), 32'h5a);
    rd(jifa_pkg::IR_FSCL, 8, 32'h5a);
    wr(jifa_pkg::IR_FADR, 16, 32'hbeef);
    rd(jifa_pkg::IR_FADR, 19, 32'hbeef);
    $display("register test done");
  endtask
  task automatic t_flash();
    wr(jifa_pkg::IR_FCON, 8, 32'h11);
    rd(jifa_pkg::IR_FCON, 8, 32'h11);
    wr(jifa_pkg::IR_FADR, 16, 32'h0010);
    wr(jifa_pkg::IR_FDAT, 8, 32'ha5);
    rd(jifa_pkg::IR_FADR, 16, 32'h0011);
    wr(jifa_pkg::IR_FADR, 16, 32'h0010);
    rd(jifa_pkg::IR_FDAT, 8, 32'ha5);
    $display("program and read test done");
  endtask
  // Second write lands mid-erase and must be dropped
  task automatic t_erase();
    wr(jifa_pkg::IR_FCON, 8, 32'h20);
    scan(1'b1, 16, 32'(jifa_pkg::IR_FDAT), r);
    scan(1'b0, 10, 32'h3a5, r);
    scan(1'b0, 10, 32'h33c, r);
    chk(32'(r[0]), 32'h1);
    idle();
    rdx(8, 32'ha5);
    wr(jifa_pkg::IR_FCON, 8, 32'h01);
    wr(jifa_pkg::IR_FADR, 16, 32'h0010);
    rd(jifa_pkg::IR_FDAT, 8, 32'hff);
    // Erase-all spares the reserved top
    wr(jifa_pkg::IR_FCON, 8, 32'h11);
    wr(jifa_pkg::IR_FADR, 16, 32'h7e00);
    wr(jifa_pkg::IR_FDAT, 8, 32'h3c);
    wr(jifa_pkg::IR_FCON, 8, 32'h21);
    wr(jifa_pkg::IR_FADR, 16, 32'hffff);
    wr(jifa_pkg::IR_FDAT, 8, 32'h00);
    wr(jifa_pkg::IR_FADR, 16, 32'h7dff);
    rd(jifa_pkg::IR_FDAT, 8, 32'hff);
    wr(jifa_pkg::IR_FADR, 16, 32'h7e00);
    rd(jifa_pkg::IR_FDAT, 8, 32'h3c);
    $display("erase test done");
  endtask
  // Reset, wait out the link reset sequence, run all scenarios
  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    do apb(1'b0, jifa_pkg::A_STAT, 32'h0, r); while (r[0] !== 1'b0);
    t_ident();
    t_regs();
    t_flash();
    t_erase();
    give_verdict();
  end
endmodule // jifa_bench
`default_nettype wire
